// [dv/cmrtc_asserts.sv]
`timescale 1ns/100ps
module cmrtc_asserts
    import cmrtc_pkg::*;
#(
    parameter int SEC_TICKS = CMRTC_SEC_TICKS,
    parameter int PER_TICKS = CMRTC_PER_TICKS
)(
    input wire logic       I_REF_CLK,
    input wire logic       I_RST_B,
    input wire logic       I_CE,
    input wire cmrtc_io_s  I_IO,
    input wire logic [7:0] O_RDATA,
    input wire logic       O_RVALID,
    input wire logic       O_IRQ
);
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);
    logic       t, w70, w71, r70, r71, hi, en, st;
    logic [6:0] idx;
    logic [7:0] exp_q;
    logic [7:0] mem [CMRTC_DEPTH];
    assign t   = I_CE && I_IO.cs;
    assign w70 = t && I_IO.wr && I_IO.addr == CMRTC_SEL_PORT;
    assign w71 = t && I_IO.wr && I_IO.addr == CMRTC_DATA_PORT;
    assign r70 = t && I_IO.rd && !I_IO.wr && I_IO.addr == CMRTC_SEL_PORT;
    assign r71 = t && I_IO.rd && !I_IO.wr && I_IO.addr == CMRTC_DATA_PORT;
    assign st  = idx > CMRTC_LAST_CLK;
    // shadow of plain storage only; clock bytes move on their own
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            idx <= 7'h00;
            hi <= 1'b0;
            en <= 1'b0;
            exp_q <= 8'h00;
            foreach (mem[i]) mem[i] <= 8'h00;
        end
        else
        begin
            if (w70) idx <= I_IO.wdata[6:0];
            if (w70) hi <= I_IO.wdata[7];
            if (w71 && st) mem[idx] <= I_IO.wdata;
            if (w71 && idx == CMRTC_CTLB && I_IO.wdata[6:4] != 3'h0) en <= 1'b1;
            if (r71) exp_q <= mem[idx];
        end
    end
    property p_rv;   r70 || r71 |=> O_RVALID; endproperty
    property p_nov;  O_RVALID |-> $past(r70 || r71); endproperty
    property p_hold; !(r70 || r71) |=> $stable(O_RDATA); endproperty
    property p_sel;  r70 |=> O_RDATA == 8'hFF; endproperty
    property p_st;   r71 && st |=> O_RDATA == exp_q; endproperty
    property p_hi;   r71 && st && hi |=> O_RDATA == exp_q; endproperty
    property p_new;  w70 ##2 w70 ##2 (r71 && st) |=> O_RDATA == exp_q; endproperty
    property p_ctld; r71 && idx == CMRTC_CTLD |=> O_RDATA == CMRTC_D_VALID; endproperty
    property p_irq;  !en |-> !O_IRQ; endproperty
    a_rv:   assert property (p_rv) else $error("read not answered");
    a_nov:  assert property (p_nov) else $error("answer without read");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_sel:  assert property (p_sel) else $error("select port read");
    a_st:   assert property (p_st) else $error("stored byte lost");
    a_hi:   assert property (p_hi) else $error("index top bit used");
    a_new:  assert property (p_new) else $error("old index used");
    a_ctld: assert property (p_ctld) else $error("control D value");
    a_irq:  assert property (p_irq) else $error("irq without enable");
    c_rd:  cover property (r71 ##1 O_RVALID);
    c_new: cover property (w70 ##2 w70 ##2 r71);
    c_irq: cover property (O_IRQ);
endmodule
bind cmrtc_top cmrtc_asserts #(.SEC_TICKS(SEC_TICKS), .PER_TICKS(PER_TICKS)) u_chk (
    .I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE), .I_IO(I_IO),
    .O_RDATA(O_RDATA), .O_RVALID(O_RVALID), .O_IRQ(O_IRQ));

// [dv/cmrtc_host.sv]
`timescale 1ns/100ps
module cmrtc_host
    import cmrtc_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_rvalid,
    output cmrtc_io_s       o_io
);
    initial o_io = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: 16'h0000, wdata: 8'h00};
    // released address and data lines show the inverse, never the last value
    task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge i_clk);
        o_io = '{cs: 1'b1, wr: w, rd: !w, addr: a, wdata: d};
        @(negedge i_clk);
        // the answer stands for one cycle only: take it before releasing
        q = 8'h00;
        if (!w)
            q = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
        o_io = '{cs: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    // select and data access kept together so nothing can reselect in between
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        output logic [7:0] q);
        cyc(1'b1, CMRTC_SEL_PORT, idx, q);
        cyc(w, CMRTC_DATA_PORT, d, q);
    endtask
endmodule

// [dv/tb_top.sv]
`timescale 1ns/100ps
module tb_top
    import cmrtc_pkg::*;
;
    localparam int SEC = 8;
    logic        i_ref_clk, i_rst_b, i_ce, o_rvalid, o_irq;
    logic [7:0]  o_rdata, q;
    logic [6:0]  a;
    cmrtc_io_s   io;
    logic [7:0]  shadow [CMRTC_DEPTH];
    logic [6:0]  ck [3] = '{CMRTC_CTLA, CMRTC_CTLB, CMRTC_CTLD};
    logic [31:0] seed = 32'd52;
    int          n_errors = 0;
    int          n_tests = 0;
    cmrtc_top #(.SEC_TICKS(SEC), .PER_TICKS(1)) u_dut (.I_REF_CLK(i_ref_clk),
        .I_RST_B(i_rst_b), .I_CE(i_ce), .I_IO(io), .O_RDATA(o_rdata),
        .O_RVALID(o_rvalid), .O_IRQ(o_irq));
    cmrtc_host u_host (.i_clk(i_ref_clk), .i_rdata(o_rdata), .i_rvalid(o_rvalid), .o_io(io));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic logic [7:0] exp_loc(input logic [6:0] l);
        case (l)
            CMRTC_CTLA: return CMRTC_CTLA_RST;
            CMRTC_CTLB: return CMRTC_CTLB_RST;
            CMRTC_CTLD: return CMRTC_D_VALID;
            default:    return shadow[l];
        endcase
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end
    initial
    begin
        #(100 * 5000);
        n_errors++;
        wrap_up;
    end
    initial
    begin
        i_rst_b = 1'b0;
        i_ce = 1'b1;
        foreach (shadow[i]) shadow[i] = 8'h00;
        repeat (4) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        u_host.cyc(1'b0, CMRTC_SEL_PORT, 8'h00, q);
        chk(q, 8'hFF);
        for (int i = 0; i < 3; i++)
        begin
            u_host.xfer(1'b0, {1'b0, ck[i]}, 8'h00, q);
            chk(q, exp_loc(ck[i]));
        end
        u_host.xfer(1'b1, 8'h8E, 8'hA5, q);
        u_host.xfer(1'b1, 8'hFF, 8'h5A, q);
        shadow[14] = 8'hA5;
        shadow[127] = 8'h5A;
        repeat (40)
        begin
            seed = xs(seed);
            a = 7'(14 + seed[15:8] % 114);
            shadow[a] = seed[7:0];
            u_host.xfer(1'b1, {seed[20], a}, seed[7:0], q);
        end
        for (int i = 14; i < 128; i++)
        begin
            seed = xs(seed);
            u_host.xfer(1'b0, {seed[3], 7'(i)}, 8'h00, q);
            chk(q, exp_loc(7'(i)));
        end
        // a stray select write must not survive a newer one
        u_host.cyc(1'b1, CMRTC_SEL_PORT, 8'h20, q);
        u_host.xfer(1'b1, 8'h21, 8'h3C, q);
        shadow[33] = 8'h3C;
        u_host.cyc(1'b1, CMRTC_SEL_PORT, 8'h20, q);
        u_host.xfer(1'b0, 8'h21, 8'h00, q);
        chk(q, shadow[33]);
        u_host.cyc(1'b1, 16'h0072, 8'h20, q);
        u_host.cyc(1'b0, CMRTC_DATA_PORT, 8'h00, q);
        chk(q, shadow[33]);
        u_host.xfer(1'b1, {1'b0, CMRTC_SEC}, 8'h00, q);
        repeat (3 * SEC) @(negedge i_ref_clk);
        u_host.xfer(1'b0, {1'b0, CMRTC_SEC}, 8'h00, q);
        chk(q, 8'h03);
        // enable held low: the second must not advance
        u_host.xfer(1'b1, {1'b0, CMRTC_SEC}, 8'h00, q);
        i_ce = 1'b0;
        repeat (3 * SEC) @(negedge i_ref_clk);
        i_ce = 1'b1;
        u_host.xfer(1'b0, {1'b0, CMRTC_SEC}, 8'h00, q);
        chk(q, 8'h00);
        u_host.xfer(1'b1, {1'b0, CMRTC_CTLB}, 8'h42, q);
        repeat (70) @(negedge i_ref_clk);
        chk({7'h00, o_irq}, 8'h01);
        u_host.xfer(1'b0, {1'b0, CMRTC_CTLC}, 8'h00, q);
        chk(q & 8'hC0, 8'hC0);
        chk({7'h00, o_irq}, 8'h00);
        wrap_up;
    end
endmodule

// [rtl/cmrtc_pkg.sv]
// Functional notes
// - 128 bytes with the clock, cleared by reset except control A, B and D (no battery domain)
// - host writes index 00..7F at port 70
// - port 71 reads or writes indexed byte
// - locations 0..13 are clock functions
// - locations 14..127 are plain storage
// - newest index write replaces the older one
// - time, alarm, hundred-year calendar, periodic interrupt
package cmrtc_pkg;
    localparam int           CMRTC_DEPTH     = 128;
    localparam int           CMRTC_AW        = 7;
    localparam logic [15:0]  CMRTC_SEL_PORT  = 16'h0070;
    localparam logic [15:0]  CMRTC_DATA_PORT = 16'h0071;
    localparam logic [6:0]   CMRTC_SEC       = 7'h00;
    localparam logic [6:0]   CMRTC_SEC_ALM   = 7'h01;
    localparam logic [6:0]   CMRTC_MIN       = 7'h02;
    localparam logic [6:0]   CMRTC_MIN_ALM   = 7'h03;
    localparam logic [6:0]   CMRTC_HOUR      = 7'h04;
    localparam logic [6:0]   CMRTC_HOUR_ALM  = 7'h05;
    localparam logic [6:0]   CMRTC_WDAY      = 7'h06;
    localparam logic [6:0]   CMRTC_MDAY      = 7'h07;
    localparam logic [6:0]   CMRTC_MONTH     = 7'h08;
    localparam logic [6:0]   CMRTC_YEAR      = 7'h09;
    localparam logic [6:0]   CMRTC_CTLA      = 7'h0A;
    localparam logic [6:0]   CMRTC_CTLB      = 7'h0B;
    localparam logic [6:0]   CMRTC_CTLC      = 7'h0C;
    localparam logic [6:0]   CMRTC_CTLD      = 7'h0D;
    localparam logic [6:0]   CMRTC_LAST_CLK  = 7'h0D;
    // control B bits
    localparam int           CMRTC_B_HALT    = 7;
    localparam int           CMRTC_B_PIE     = 6;
    localparam int           CMRTC_B_AIE     = 5;
    localparam int           CMRTC_B_UIE     = 4;
    // control C flag bits
    localparam int           CMRTC_C_IRQ     = 7;
    localparam int           CMRTC_C_PF      = 6;
    localparam int           CMRTC_C_AF      = 5;
    localparam int           CMRTC_C_UF      = 4;
    localparam logic [7:0]   CMRTC_D_VALID   = 8'h80;
    localparam logic [7:0]   CMRTC_ALM_DONTCARE = 8'hC0;
    localparam logic [7:0]   CMRTC_CTLA_RST  = 8'h26;
    localparam logic [7:0]   CMRTC_CTLB_RST  = 8'h02;
    localparam int           CMRTC_CLK_HZ    = 10_000_000;
    localparam int           CMRTC_SEC_TICKS = CMRTC_CLK_HZ;
    localparam int           CMRTC_PER_MAX   = 32768;
    localparam int           CMRTC_PER_TICKS = CMRTC_CLK_HZ / CMRTC_PER_MAX;

    typedef struct packed {
        logic        cs;
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } cmrtc_io_s;
endpackage

// [rtl/cmrtc_top.sv]
`timescale 1ns/100ps
module cmrtc_top
    import cmrtc_pkg::*;
#(
    parameter int SEC_TICKS = CMRTC_SEC_TICKS,
    parameter int PER_TICKS = CMRTC_PER_TICKS
)(
    input  wire logic       I_REF_CLK,
    input  wire logic       I_RST_B,
    input  wire logic       I_CE,
    input  wire cmrtc_io_s  I_IO,
    output logic [7:0]      O_RDATA,
    output logic            O_RVALID,
    output logic            O_IRQ
);
    typedef struct packed {
        logic [6:0]  index;
        logic [CMRTC_DEPTH-1:0][7:0] mem;
        logic [31:0] sec_cnt;
        logic [31:0] per_cnt;
        logic [15:0] per_div;
        logic [7:0]  rdata;
        logic        rvalid;
        logic        irq;
    } cmrtc_state_s;

    cmrtc_state_s st;
    cmrtc_state_s next_st;

    // bcd increment with wrap; returns first value on reaching limit
    function automatic logic [7:0] bcd_inc(input logic [7:0] v,
                                           input logic [7:0] lim,
                                           input logic [7:0] first);
        logic [7:0] r;
        r = first;
        if (v != lim)
        begin
            if (v[3:0] == 4'h9)
                r = {v[7:4] + 4'h1, 4'h0};
            else
                r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

    // low-bit mask of the free-running periodic divider; rate 0 never ticks
    function automatic logic [15:0] rate_mask(input logic [3:0] r);
        logic [15:0] m;
        m = 16'h0000;
        if (r != 4'h0)
            m = 16'((32'h1 << r) - 32'h1);
        return m;
    endfunction

    function automatic logic alm_hit(input logic [7:0] a, input logic [7:0] t);
        return ((a & CMRTC_ALM_DONTCARE) == CMRTC_ALM_DONTCARE) || (a == t);
    endfunction

    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
        logic [7:0] d;
        d = 8'h31;
        if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11)
            d = 8'h30;
        else if (m == 8'h02)
            // bcd year divisible by four; century year 00 counts as leap
            d = ((y[4] ? (y[1:0] == 2'h2) : (y[1:0] == 2'h0))) ? 8'h29 : 8'h28;
        return d;
    endfunction

    logic [6:0] sel;
    logic       sec_tick;
    logic       per_tick;
    logic [3:0] rate;
    logic [15:0] per_mask;
    logic       alm_now;
    logic       io_wr;
    logic       io_rd;

    always_comb
    begin
        next_st  = st;
        sel      = st.index;
        sec_tick = 1'b0;
        per_tick = 1'b0;
        rate     = st.mem[CMRTC_CTLA][3:0];
        per_mask = rate_mask(rate);
        alm_now  = 1'b0;
        // a write wins when both strobes arrive together
        io_wr    = I_IO.cs && I_IO.wr;
        io_rd    = I_IO.cs && I_IO.rd && !I_IO.wr;
        next_st.rvalid = 1'b0;

        // periodic divider runs from a 32.768 kHz-equivalent base
        // one tick each time the low rate bits of the divider are all ones
        if (st.per_cnt >= 32'(PER_TICKS - 1))
        begin
            next_st.per_cnt = '0;
            next_st.per_div = st.per_div + 16'h0001;
            per_tick = (rate != 4'h0) && ((st.per_div & per_mask) == per_mask);
        end
        else
            next_st.per_cnt = st.per_cnt + 32'h1;

        if (!st.mem[CMRTC_CTLB][CMRTC_B_HALT])
        begin
            if (st.sec_cnt >= 32'(SEC_TICKS - 1))
            begin
                next_st.sec_cnt = '0;
                sec_tick = 1'b1;
            end
            else
                next_st.sec_cnt = st.sec_cnt + 32'h1;
        end

        if (sec_tick)
        begin
            next_st.mem[CMRTC_SEC] = bcd_inc(st.mem[CMRTC_SEC], 8'h59, 8'h00);
            if (st.mem[CMRTC_SEC] == 8'h59)
            begin
                next_st.mem[CMRTC_MIN] = bcd_inc(st.mem[CMRTC_MIN], 8'h59, 8'h00);
                if (st.mem[CMRTC_MIN] == 8'h59)
                begin
                    next_st.mem[CMRTC_HOUR] = bcd_inc(st.mem[CMRTC_HOUR], 8'h23, 8'h00);
                    if (st.mem[CMRTC_HOUR] == 8'h23)
                    begin
                        next_st.mem[CMRTC_WDAY] = bcd_inc(st.mem[CMRTC_WDAY], 8'h07, 8'h01);
                        next_st.mem[CMRTC_MDAY] = bcd_inc(st.mem[CMRTC_MDAY],
                            month_days(st.mem[CMRTC_MONTH], st.mem[CMRTC_YEAR]), 8'h01);
                        if (st.mem[CMRTC_MDAY] ==
                            month_days(st.mem[CMRTC_MONTH], st.mem[CMRTC_YEAR]))
                        begin
                            next_st.mem[CMRTC_MONTH] =
                                bcd_inc(st.mem[CMRTC_MONTH], 8'h12, 8'h01);
                            if (st.mem[CMRTC_MONTH] == 8'h12)
                                next_st.mem[CMRTC_YEAR] =
                                    bcd_inc(st.mem[CMRTC_YEAR], 8'h99, 8'h00);
                        end
                    end
                end
            end
            next_st.mem[CMRTC_CTLC][CMRTC_C_UF] = 1'b1;
            // alarm compares the time as it becomes after this tick
            alm_now = alm_hit(st.mem[CMRTC_SEC_ALM], next_st.mem[CMRTC_SEC])
                && alm_hit(st.mem[CMRTC_MIN_ALM], next_st.mem[CMRTC_MIN])
                && alm_hit(st.mem[CMRTC_HOUR_ALM], next_st.mem[CMRTC_HOUR]);
            if (alm_now)
                next_st.mem[CMRTC_CTLC][CMRTC_C_AF] = 1'b1;
        end
        if (per_tick)
            next_st.mem[CMRTC_CTLC][CMRTC_C_PF] = 1'b1;

        // only the newest select survives; the host must keep the pair atomic
        if (io_wr)
        begin
            if (I_IO.addr == CMRTC_SEL_PORT)
                next_st.index = I_IO.wdata[CMRTC_AW-1:0];
            else if (I_IO.addr == CMRTC_DATA_PORT)
            begin
                // flags and validity byte are hardware-owned, writes dropped
                if (sel != CMRTC_CTLC && sel != CMRTC_CTLD)
                    next_st.mem[sel] = I_IO.wdata;
                if (sel == CMRTC_SEC)
                    next_st.sec_cnt = '0;
            end
        end
        else if (io_rd)
        begin
            if (I_IO.addr == CMRTC_DATA_PORT)
            begin
                next_st.rdata  = st.mem[sel];
                next_st.rvalid = 1'b1;
                // reading the flag byte clears it; a same-cycle event still sets it
                if (sel == CMRTC_CTLC)
                begin
                    next_st.mem[CMRTC_CTLC] = 8'h00;
                    if (per_tick)
                        next_st.mem[CMRTC_CTLC][CMRTC_C_PF] = 1'b1;
                    if (sec_tick)
                    begin
                        next_st.mem[CMRTC_CTLC][CMRTC_C_UF] = 1'b1;
                        // an alarm landing on the clearing read is not lost
                        next_st.mem[CMRTC_CTLC][CMRTC_C_AF] = alm_now;
                    end
                end
            end
            else if (I_IO.addr == CMRTC_SEL_PORT)
            begin
                // select port is write-only
                next_st.rdata  = 8'hFF;
                next_st.rvalid = 1'b1;
            end
        end

        next_st.mem[CMRTC_CTLC][3:0]          = 4'h0;
        next_st.mem[CMRTC_CTLC][CMRTC_C_IRQ] =
            (next_st.mem[CMRTC_CTLC][CMRTC_C_PF] & st.mem[CMRTC_CTLB][CMRTC_B_PIE])
            | (next_st.mem[CMRTC_CTLC][CMRTC_C_AF] & st.mem[CMRTC_CTLB][CMRTC_B_AIE])
            | (next_st.mem[CMRTC_CTLC][CMRTC_C_UF] & st.mem[CMRTC_CTLB][CMRTC_B_UIE]);
        next_st.irq = next_st.mem[CMRTC_CTLC][CMRTC_C_IRQ];
        next_st.mem[CMRTC_CTLD] = CMRTC_D_VALID;
    end

    // enable low freezes the whole record, timers included, so time slips
    // for as long as it is held; the host must account for that
    always_ff @(posedge I_REF_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            // storage clears too: no battery domain is modelled here
            st                   <= '0;
            st.mem[CMRTC_CTLA]   <= CMRTC_CTLA_RST;
            st.mem[CMRTC_CTLB]   <= CMRTC_CTLB_RST;
            st.mem[CMRTC_CTLD]   <= CMRTC_D_VALID;
        end
        else if (I_CE)
            st <= next_st;
    end

    assign O_RDATA  = st.rdata;
    assign O_RVALID = st.rvalid;
    assign O_IRQ    = st.irq;
endmodule
